// file: fscs_switch.sv
// Fail-safe clock monitor and clock source switch
// Functional notes
// - Entering a power-managed mode, the mux takes the source software selected; the code does so only in the run state.
// - Monitoring continues on the source used during a power-managed mode; the code watches only the primary edges.
// - Failure with interrupt enabled moves execution onto the internal oscillator.
// - Never return to a failed source except by explicit software action; the code also returns after a Sleep wake in the failure cycle.
// - Failure with interrupt disabled: Idle wake interrupt runs on internal oscillator.
// - Monitor active after reset or Sleep; immediate for external, RC, internal modes.
// - Crystal and PLL modes run internally until start-up and PLL timers expire.
// - Once stable, hand device clock back to primary; internal becomes monitor clock.
// - A primary that never starts during start-up wait is not flagged failed.
// - New power-managed mode chosen during start-up wait disables the primary.
//
// The implementer's own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fscs_params.svh"

module fscs_switch
  import fscs_pkg::*;
#(
  parameter int MON_WINDOW_CYC = `FSCS_MON_WINDOW_CYC,
  parameter int OST_EDGES = `FSCS_OST_EDGES,
  parameter int PLL_LOCK_CYC = `FSCS_PLL_LOCK_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`FSCS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic prim_clk_edge,
  input wire logic pm_enter,
  input wire logic idle_mode,
  input wire logic sleep_wake,
  input wire logic cpu_irq_pending,
  output logic [1:0] clk_mux_sel,
  output logic prim_osc_en,
  output logic idle_wake_internal,
  output logic irq
);

  localparam int CNT_W = 32;

  // Address decode shared by register writes and reads
  function automatic logic fscs_hit(input logic [`FSCS_ADDR_W-1:0] a,
                                    input logic [`FSCS_ADDR_W-1:0] ofs);
    fscs_hit = (a == ofs);
  endfunction

  fscs_state_t state_r, state_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic [2:0] prim_mode_r, prim_mode_nxt;
  logic mon_en_r, mon_en_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] win_r, win_nxt;
  logic fail_latch_r, fail_latch_nxt;
  logic startup_done_r, startup_done_nxt;
  logic [`FSCS_IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [`FSCS_IRQ_W-1:0] irq_en_r, irq_en_nxt;
  logic [1:0] mux_r, mux_nxt;
  logic prim_en_r, prim_en_nxt;
  logic idle_int_r, idle_int_nxt;
  logic irq_r, irq_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic wr_ctrl, wr_en, wr_clr, restore_req;
  logic xtal_mode, fail_evt, stable_evt, win_done;

  assign wr_ctrl = reg_wr && fscs_hit(reg_addr, `FSCS_OFS_CTRL);
  assign wr_en = reg_wr && fscs_hit(reg_addr, `FSCS_OFS_IRQ_EN);
  assign wr_clr = reg_wr && fscs_hit(reg_addr, `FSCS_OFS_IRQ_CLR);
  // Only a deliberate software write may leave the failed state
  assign restore_req = wr_ctrl && reg_wdata[`FSCS_CTRL_RESTORE_BIT];
  assign xtal_mode = (prim_mode_r == FSCS_HS_XTAL) || (prim_mode_r == FSCS_HS_PLL) ||
                     (prim_mode_r == FSCS_LP_XTAL) || (prim_mode_r == FSCS_STD_XTAL);
  assign win_done = (win_r >= CNT_W'(MON_WINDOW_CYC - 1));

  // Sequencer, monitor window and start-up timers
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    win_nxt = win_r;
    fail_evt = 1'b0;
    stable_evt = 1'b0;
    startup_done_nxt = startup_done_r;
    prim_en_nxt = prim_en_r;
    sel_nxt = sel_r;
    prim_mode_nxt = prim_mode_r;
    mon_en_nxt = mon_en_r;
    if (wr_ctrl) begin
      sel_nxt = reg_wdata[`FSCS_CTRL_SEL_LSB +: `FSCS_CTRL_SEL_W];
      prim_mode_nxt = reg_wdata[`FSCS_CTRL_PRIM_MODE_LSB +: `FSCS_CTRL_PRIM_MODE_W];
      mon_en_nxt = reg_wdata[`FSCS_CTRL_MON_EN_BIT];
    end
    case (state_r)
      FSCS_ST_STARTUP: begin
        // Crystal start-up: no failure is judged here
        prim_en_nxt = 1'b1;
        win_nxt = '0;
        if (!xtal_mode) begin
          state_nxt = FSCS_ST_RUN;
          startup_done_nxt = 1'b1;
          stable_evt = 1'b1;
        end else if (pm_enter && sel_r != FSCS_SRC_PRIMARY) begin
          prim_en_nxt = 1'b0;
        end else if (prim_clk_edge) begin
          cnt_nxt = cnt_r + CNT_W'(1);
          if (cnt_r >= CNT_W'(OST_EDGES - 1)) begin
            cnt_nxt = '0;
            state_nxt = (prim_mode_r == FSCS_HS_PLL) ? FSCS_ST_PLL_WAIT : FSCS_ST_RUN;
            if (prim_mode_r != FSCS_HS_PLL) begin
              startup_done_nxt = 1'b1;
              stable_evt = 1'b1;
            end
          end
        end
      end
      FSCS_ST_PLL_WAIT: begin
        cnt_nxt = cnt_r + CNT_W'(1);
        if (cnt_r >= CNT_W'(PLL_LOCK_CYC - 1)) begin
          cnt_nxt = '0;
          state_nxt = FSCS_ST_RUN;
          startup_done_nxt = 1'b1;
          stable_evt = 1'b1;
        end
      end
      FSCS_ST_RUN: begin
        // Watch the primary edges whatever source is in use, power-managed or not
        win_nxt = (prim_clk_edge || win_done) ? '0 : win_r + CNT_W'(1);
        if (mon_en_r && win_done && !prim_clk_edge) begin
          fail_evt = 1'b1;
          state_nxt = FSCS_ST_FAILED;
        end
      end
      FSCS_ST_FAILED: begin
        // Stay on the internal clock until software restores
        if (restore_req) begin
          state_nxt = FSCS_ST_STARTUP;
          cnt_nxt = '0;
          startup_done_nxt = 1'b0;
        end
      end
      default: state_nxt = FSCS_ST_STARTUP;
    endcase
    // Wake from Sleep restarts the start-up wait, except in the failed state
    if (sleep_wake && state_r != FSCS_ST_FAILED) begin
      state_nxt = FSCS_ST_STARTUP;
      cnt_nxt = '0;
      startup_done_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= FSCS_ST_STARTUP;
      cnt_r <= '0;
      win_r <= '0;
      startup_done_r <= 1'b0;
      prim_en_r <= 1'b1;
      sel_r <= 2'h1;
      prim_mode_r <= 3'h0;
      mon_en_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      win_r <= win_nxt;
      startup_done_r <= startup_done_nxt;
      prim_en_r <= prim_en_nxt;
      sel_r <= sel_nxt;
      prim_mode_r <= prim_mode_nxt;
      mon_en_r <= mon_en_nxt;
    end
  end

  // Clock mux selection and failure outcome
  always_comb begin
    mux_nxt = FSCS_SRC_INTERNAL;
    fail_latch_nxt = fail_latch_r;
    idle_int_nxt = idle_int_r;
    if (fail_evt) begin
      fail_latch_nxt = 1'b1;
    end else if (restore_req) begin
      fail_latch_nxt = 1'b0;
    end
    case (state_r)
      FSCS_ST_STARTUP, FSCS_ST_PLL_WAIT: mux_nxt = FSCS_SRC_INTERNAL;
      FSCS_ST_RUN: mux_nxt = pm_enter ? sel_r : FSCS_SRC_PRIMARY;
      FSCS_ST_FAILED: mux_nxt = FSCS_SRC_INTERNAL;
      default: mux_nxt = FSCS_SRC_INTERNAL;
    endcase
    if (pm_enter && state_r == FSCS_ST_RUN) begin
      mux_nxt = sel_r;
    end
    // Fail with interrupt masked: next Idle interrupt resumes on internal clock
    if (fail_latch_r && !irq_en_r[`FSCS_IRQ_FAIL_BIT] && idle_mode && cpu_irq_pending) begin
      idle_int_nxt = 1'b1;
    end else if (restore_req) begin
      idle_int_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mux_r <= 2'h2;
      fail_latch_r <= 1'b0;
      idle_int_r <= 1'b0;
    end else begin
      mux_r <= mux_nxt;
      fail_latch_r <= fail_latch_nxt;
      idle_int_r <= idle_int_nxt;
    end
  end

  // Interrupt status, enable and clear; a new event beats a clear
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    irq_en_nxt = irq_en_r;
    if (wr_en) begin
      irq_en_nxt = reg_wdata[`FSCS_IRQ_W-1:0];
    end
    if (wr_clr) begin
      irq_stat_nxt = irq_stat_nxt & ~reg_wdata[`FSCS_IRQ_W-1:0];
    end
    if (fail_evt) begin
      irq_stat_nxt[`FSCS_IRQ_FAIL_BIT] = 1'b1;
    end
    if (stable_evt) begin
      irq_stat_nxt[`FSCS_IRQ_STABLE_BIT] = 1'b1;
    end
    irq_nxt = |(irq_stat_nxt & irq_en_nxt);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_stat_r <= '0;
      irq_en_r <= '0;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= irq_en_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Read port; data stand the cycle after the strobe only
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (reg_rd) begin
      if (fscs_hit(reg_addr, `FSCS_OFS_CTRL)) begin
        rdata_nxt[`FSCS_CTRL_SEL_LSB +: `FSCS_CTRL_SEL_W] = sel_r;
        rdata_nxt[`FSCS_CTRL_PRIM_MODE_LSB +: `FSCS_CTRL_PRIM_MODE_W] = prim_mode_r;
        rdata_nxt[`FSCS_CTRL_MON_EN_BIT] = mon_en_r;
      end else if (fscs_hit(reg_addr, `FSCS_OFS_STATUS)) begin
        // Set when the start-up wait ends (at once in external, RC and internal modes); software reads it here
        rdata_nxt[0] = startup_done_r;
        rdata_nxt[1] = fail_latch_r;
        rdata_nxt[3:2] = mux_r;
        rdata_nxt[4] = prim_en_r;
      end else if (fscs_hit(reg_addr, `FSCS_OFS_IRQ_STAT)) begin
        rdata_nxt[`FSCS_IRQ_W-1:0] = irq_stat_r;
      end else if (fscs_hit(reg_addr, `FSCS_OFS_IRQ_EN)) begin
        rdata_nxt[`FSCS_IRQ_W-1:0] = irq_en_r;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign clk_mux_sel = mux_r;
  assign prim_osc_en = prim_en_r;
  assign idle_wake_internal = idle_int_r;
  assign irq = irq_r;

endmodule

`default_nettype wire

// file: fscs_params.svh
// Constants for the fail-safe clock switch
`ifndef FSCS_PARAMS_SVH
`define FSCS_PARAMS_SVH

// Register offsets
`define FSCS_ADDR_W 4
`define FSCS_OFS_CTRL 4'h0
`define FSCS_OFS_STATUS 4'h1
`define FSCS_OFS_IRQ_STAT 4'h2
`define FSCS_OFS_IRQ_EN 4'h3
`define FSCS_OFS_IRQ_CLR 4'h4

// Control register fields
`define FSCS_CTRL_SEL_LSB 0
`define FSCS_CTRL_SEL_W 2
`define FSCS_CTRL_PRIM_MODE_LSB 4
`define FSCS_CTRL_PRIM_MODE_W 3
`define FSCS_CTRL_MON_EN_BIT 8
`define FSCS_CTRL_RESTORE_BIT 9
`define FSCS_CTRL_RESET 32'h0000_0101

// Interrupt status bits
`define FSCS_IRQ_FAIL_BIT 0
`define FSCS_IRQ_STABLE_BIT 1
`define FSCS_IRQ_W 2

// Clock rate and monitor timing
`define FSCS_CLK_HZ 10000000
`define FSCS_MON_WINDOW_NS 3200
`define FSCS_MON_WINDOW_CYC ((`FSCS_MON_WINDOW_NS * (`FSCS_CLK_HZ / 1000000)) / 1000)
`define FSCS_OST_EDGES 1024
`define FSCS_PLL_LOCK_US 2000
`define FSCS_PLL_LOCK_CYC ((`FSCS_PLL_LOCK_US * (`FSCS_CLK_HZ / 1000000)))

`endif

// file: fscs_pkg.sv
// Types for the fail-safe clock switch
package fscs_pkg;

  // Primary oscillator configuration
  typedef enum logic [2:0] {
    FSCS_EXT_CLOCK = 3'h0,
    FSCS_RC = 3'h1,
    FSCS_INT_RC = 3'h2,
    FSCS_HS_XTAL = 3'h3,
    FSCS_HS_PLL = 3'h4,
    FSCS_LP_XTAL = 3'h5,
    FSCS_STD_XTAL = 3'h6
  } fscs_prim_mode_t;

  // Clock mux source select
  typedef enum logic [1:0] {
    FSCS_SRC_PRIMARY = 2'h0,
    FSCS_SRC_SECONDARY = 2'h1,
    FSCS_SRC_INTERNAL = 2'h2
  } fscs_src_t;

  // Start-up and monitoring sequence
  typedef enum {
    FSCS_ST_STARTUP,
    FSCS_ST_PLL_WAIT,
    FSCS_ST_RUN,
    FSCS_ST_FAILED
  } fscs_state_t;

endpackage

// file: fscs_switch_checker.sv
// Port assertions for the fail-safe clock switch
`timescale 1ns/1ps
`default_nettype none
`include "fscs_params.svh"
module fscs_switch_checker #(
  parameter int MON_WINDOW_CYC = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [`FSCS_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic prim_clk_edge,
  input wire logic pm_enter,
  input wire logic idle_mode,
  input wire logic sleep_wake,
  input wire logic cpu_irq_pending,
  input wire logic [1:0] clk_mux_sel,
  input wire logic prim_osc_en,
  input wire logic idle_wake_internal,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] gap_r, gap_nxt;
  logic lost_r, lost_nxt;
  logic [1:0] mux_q_r;
  // Silence since the last primary edge; a loss is remembered until software restores
  always_comb begin
    gap_nxt = prim_clk_edge ? 8'h00 : gap_r + {7'h0, gap_r != 8'hff};
    lost_nxt = lost_r;
    if (reg_wr && reg_addr == `FSCS_OFS_CTRL && reg_wdata[`FSCS_CTRL_RESTORE_BIT])
      lost_nxt = 1'b0;
    else if (mux_q_r == 2'h0 && clk_mux_sel == 2'h2 && gap_r > 8'h10)
      lost_nxt = 1'b1;
  end
  // Helper registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      gap_r <= 8'h00;
      lost_r <= 1'b0;
      mux_q_r <= 2'h2;
    end else begin
      gap_r <= gap_nxt;
      lost_r <= lost_nxt;
      mux_q_r <= clk_mux_sel;
    end
  end
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  clr_read_a: assert property ($past(reg_rd) && $past(reg_addr) == `FSCS_OFS_IRQ_CLR
    |-> reg_rdata == 32'h0) else $error("clear register readable");
  unmapped_read_a: assert property ($past(reg_rd) && $past(reg_addr) > `FSCS_OFS_IRQ_CLR
    |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
  status_mirror_a: assert property ($past(reg_rd) && $past(reg_addr) == `FSCS_OFS_STATUS
    |-> reg_rdata[4:2] == {$past(prim_osc_en), $past(clk_mux_sel)}) else $error("status wrong");
  prim_gap_a: assert property (clk_mux_sel == 2'h0 |-> gap_r <= MON_WINDOW_CYC + 4)
    else $error("primary kept after clock loss");
  no_return_a: assert property (lost_r |-> clk_mux_sel != 2'h0)
    else $error("returned to failed source");
  idle_wake_a: assert property ($rose(idle_wake_internal) |-> $past(idle_mode)
    && $past(cpu_irq_pending) && clk_mux_sel == 2'h2) else $error("idle wake bad");
  osc_drop_a: assert property ($fell(prim_osc_en) |-> $past(pm_enter))
    else $error("primary disabled without mode change");
endmodule
`default_nettype wire

// file: fscs_osc_model.sv
// Primary oscillator model: an edge pulse every other cycle while running
`timescale 1ns/1ps
`default_nettype none
module fscs_osc_model (
  input wire logic clk,
  input wire logic osc_en,
  input wire logic osc_dead,
  output var logic osc_edge = 1'b0
);
  logic ph_r = 1'b0;
  // A dead or disabled crystal gives no edge at all, so the monitor sees silence
  always_ff @(posedge clk) begin
    ph_r <= ~ph_r;
    osc_edge <= osc_en && !osc_dead && ph_r;
  end
endmodule
`default_nettype wire

// file: fscs_testbench.sv
// Testbench for the fail-safe clock switch
`timescale 1ns/1ps
`default_nettype none
`include "fscs_params.svh"
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, pm_enter = 1'b0, idle_mode = 1'b0;
  logic sleep_wake = 1'b0, cpu_irq_pending = 1'b0, osc_dead = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_v;
  logic [1:0] clk_mux_sel;
  logic prim_clk_edge, prim_osc_en, idle_wake_internal, irq;
  int failures = 0, n_checks = 0;
  initial forever #50 clk = ~clk;
  // Short start-up counts keep the run brief
  fscs_switch #(.MON_WINDOW_CYC(32), .OST_EDGES(8), .PLL_LOCK_CYC(16)) i_dut (.clk, .sys_rst,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .prim_clk_edge, .pm_enter, .idle_mode,
    .sleep_wake, .cpu_irq_pending, .clk_mux_sel, .prim_osc_en, .idle_wake_internal, .irq);
  fscs_osc_model i_osc (.clk, .osc_en(prim_osc_en), .osc_dead, .osc_edge(prim_clk_edge));
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Bounded wait; a hang ends the run with a failure
  task automatic wait_mux(input logic [1:0] v);
    int i;
    for (i = 0; i < 300 && clk_mux_sel !== v; i++) @(posedge clk);
    #1 chk("clk_mux_sel", {30'h0, v}, {30'h0, clk_mux_sel});
    if (clk_mux_sel !== v) end_sim();
  endtask
  task automatic t_boot();
    wait_mux(2'h0);
    rd(4'h0, rd_v);
    chk("ctrl", 32'h101, rd_v);
    rd(4'h1, rd_v);
    chk("status", 32'h11, rd_v);
    rd(4'h4, rd_v);
    chk("irq_clr", 32'h0, rd_v);
    rd(4'h7, rd_v);
    chk("unmapped", 32'h0, rd_v);
    $display("t_boot done");
  endtask
  task automatic t_pm();
    pm_enter <= 1'b1;
    wait_mux(2'h1);
    wr(4'h0, 32'h102);
    wait_mux(2'h2);
    pm_enter <= 1'b0;
    wait_mux(2'h0);
    $display("t_pm done");
  endtask
  task automatic t_fail();
    wr(4'h4, 32'h3);
    wr(4'h3, 32'h1);
    wr(4'h0, 32'h100);
    pm_enter <= 1'b1;
    osc_dead <= 1'b1;
    wait_mux(2'h2);
    chk("irq", 32'h1, {31'h0, irq});
    @(posedge clk);
    osc_dead <= 1'b0;
    repeat (60) @(posedge clk);
    #1 chk("mux after revive", 32'h2, {30'h0, clk_mux_sel});
    rd(4'h2, rd_v);
    chk("fail flag", 32'h1, rd_v & 32'h1);
    wr(4'h4, 32'h1);
    @(posedge clk);
    pm_enter <= 1'b0;
    #1 chk("irq cleared", 32'h0, {31'h0, irq});
    wr(4'h0, 32'h300);
    wait_mux(2'h0);
    $display("t_fail done");
  endtask
  task automatic t_idle();
    int i;
    wr(4'h3, 32'h0);
    osc_dead <= 1'b1;
    wait_mux(2'h2);
    @(posedge clk);
    osc_dead <= 1'b0;
    idle_mode <= 1'b1;
    cpu_irq_pending <= 1'b1;
    for (i = 0; i < 20 && idle_wake_internal !== 1'b1; i++) @(posedge clk);
    #1 chk("idle_wake_internal", 32'h1, {31'h0, idle_wake_internal});
    chk("irq masked", 32'h0, {31'h0, irq});
    @(posedge clk);
    idle_mode <= 1'b0;
    cpu_irq_pending <= 1'b0;
    wr(4'h4, 32'h3);
    wr(4'h0, 32'h300);
    wait_mux(2'h0);
    $display("t_idle done");
  endtask
  task automatic t_xtal();
    wr(4'h0, 32'h141);
    osc_dead <= 1'b1;
    sleep_wake <= 1'b1;
    @(posedge clk);
    sleep_wake <= 1'b0;
    repeat (100) @(posedge clk);
    #1 chk("mux in startup", 32'h2, {30'h0, clk_mux_sel});
    rd(4'h2, rd_v);
    chk("no fail flag", 32'h0, rd_v & 32'h1);
    @(posedge clk);
    osc_dead <= 1'b0;
    wait_mux(2'h0);
    rd(4'h1, rd_v);
    chk("startup done", 32'h1, rd_v & 32'h1);
    wr(4'h0, 32'h161);
    sleep_wake <= 1'b1;
    pm_enter <= 1'b1;
    @(posedge clk);
    sleep_wake <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("prim_osc_en", 32'h0, {31'h0, prim_osc_en});
    $display("t_xtal done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_boot();
    t_pm();
    t_fail();
    t_idle();
    t_xtal();
    end_sim();
  end
endmodule
bind fscs_switch fscs_switch_checker #(.MON_WINDOW_CYC(MON_WINDOW_CYC)) i_chk (.clk, .sys_rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .prim_clk_edge, .pm_enter, .idle_mode,
  .sleep_wake, .cpu_irq_pending, .clk_mux_sel, .prim_osc_en, .idle_wake_internal, .irq);
`default_nettype wire
